//--- design/acr_ctrl_regs.sv
// control registers of the accelerometer behind its two-wire serial slave
//
// Notes on behaviour
// [R1] run bit selects standby or active operation
// [R2] performance bit picks low current or high
// [R3] main fields change only while stopped
// [R4] new-sample interrupt only when its enable set
// [R5] range code picks 2, 4 or 8 g
// [R6] 14-bit results need code 11 and full power
// [R7] motion-detect function follows its enable bit
// [R8] aux control written only while stopped
// [R9] reboot bit reads one until reboot ends
// [R10] self-test bit arms 0xAA, response read clears
// [R11] three bits set the motion sample rate
// [R12] pin config written only while stopped
// [R13] pin enable bit gates the interrupt output
// [R14] polarity bit, active high after reset
// [R15] pin latches until release or pulses once
// [R16] actuation polarity bit: negative or positive
// [R17] six axis enables, all set, stopped-only writes
// [R18] release read clears sources and latched pin
// [R19] response reads 0x55 unless self-test armed
// [R20] protected writes while running are dropped
// [R21] reserved bits read zero, ignore writes
`timescale 1ns/100ps
module acr_ctrl_regs #(
   // slave address on the link; value is arbitrary
   parameter logic [6:0] DEV_ADDR = 7'h2A,
   parameter int REBOOT_CYCLES = 64
) (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n_o,
   input wire logic new_sample_i,
   input wire logic [5:0] motion_event_i,
   output logic irq_o,
   output logic run_o,
   output logic performance_o,
   output logic bandwidth_half_rate_o,
   output logic [1:0] range_o,
   output logic [1:0] result_width_o,
   output logic motion_detect_enable_o,
   output logic [2:0] motion_rate_o,
   output logic actuation_polarity_o,
   output logic reboot_busy_o
);
   // link synchronisers; stage one is read by stage two only
   logic scl_s1, scl_s2, scl_s3;
   logic sda_s1, sda_s2, sda_s3;
   logic scl_rise, scl_fall, start_seen, stop_seen;

   acr_pkg::acr_link_state_t state_reg, state_next;
   logic [3:0] bit_cnt_reg, bit_cnt_next;
   logic [7:0] shift_reg, shift_next;
   logic [7:0] ptr_reg, ptr_next;
   logic [7:0] wr_data_reg, wr_data_next;
   logic [7:0] rd_addr_reg, rd_addr_next;
   logic ack_ph_reg, ack_ph_next;
   logic drive_reg, drive_next;
   logic nack_reg, nack_next;
   logic wr_stb_reg, wr_stb_next;
   logic rd_stb_reg, rd_stb_next;
   logic [7:0] ptr_inc, rd_cur, rd_inc;

   logic [7:0] main_reg, main_next;
   logic [7:0] aux_reg, aux_next;
   logic [7:0] pin_reg, pin_next;
   logic [7:0] axis_reg, axis_next;
   logic [7:0] src_func_reg, src_func_next;
   logic [7:0] src_axis_reg, src_axis_next;
   logic [15:0] reboot_cnt_reg, reboot_cnt_next;
   logic [1:0] width_reg, width_next;
   logic event_reg, event_next;
   logic release_reg, release_next;
   logic [7:0] axis_hits;
   logic running, wr_ok;

   function automatic logic [7:0] read_value(input logic [7:0] a);
      logic [7:0] v;
      v = acr_pkg::BYTE_ZERO;
      if (a == acr_pkg::ADDR_SELFTEST_RESP)
      begin
         v = aux_reg[acr_pkg::SELFTEST_BIT] ? acr_pkg::RESP_TEST
                                            : acr_pkg::RESP_IDLE; // R19
      end
      else if (a == acr_pkg::ADDR_SRC_FUNC)
      begin
         v = src_func_reg;
      end
      else if (a == acr_pkg::ADDR_SRC_AXIS)
      begin
         v = src_axis_reg;
      end
      else if (a == acr_pkg::ADDR_STATUS)
      begin
         v[acr_pkg::STATUS_IRQ_BIT] = |src_func_reg;
      end
      else if (a == acr_pkg::ADDR_MAIN_CONTROL)
      begin
         v = main_reg;
      end
      else if (a == acr_pkg::ADDR_AUX_CONTROL)
      begin
         v = aux_reg;
      end
      else if (a == acr_pkg::ADDR_IRQ_PIN_CONFIG)
      begin
         v = pin_reg;
      end
      else if (a == acr_pkg::ADDR_MOTION_AXIS_EN)
      begin
         v = axis_reg;
      end
      return v;
   endfunction : read_value

   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         {scl_s1, scl_s2, scl_s3} <= 3'h7;
         {sda_s1, sda_s2, sda_s3} <= 3'h7;
      end
      else
      begin
         {scl_s1, scl_s2, scl_s3} <= {scl_i, scl_s1, scl_s2};
         {sda_s1, sda_s2, sda_s3} <= {sda_i, sda_s1, sda_s2};
      end
   end

   assign scl_rise = scl_s2 & ~scl_s3;
   assign scl_fall = ~scl_s2 & scl_s3;
   assign start_seen = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
   assign stop_seen = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;
   assign ptr_inc = ptr_reg + 8'h01;
   assign rd_cur = read_value(ptr_reg);
   assign rd_inc = read_value(ptr_inc);

   // sample on scl rise, change sda on scl fall
   always_comb
   begin
      state_next = state_reg;
      bit_cnt_next = bit_cnt_reg;
      shift_next = shift_reg;
      ptr_next = ptr_reg;
      wr_data_next = wr_data_reg;
      rd_addr_next = rd_addr_reg;
      ack_ph_next = ack_ph_reg;
      drive_next = drive_reg;
      nack_next = nack_reg;
      wr_stb_next = 1'b0;
      rd_stb_next = 1'b0;
      if (stop_seen)
      begin
         state_next = acr_pkg::ACR_ST_IDLE;
         drive_next = 1'b0;
      end
      else if (start_seen)
      begin
         state_next = acr_pkg::ACR_ST_ADDR;
         bit_cnt_next = '0;
         ack_ph_next = 1'b0;
         drive_next = 1'b0;
      end
      else
      begin
         case (state_reg)
            acr_pkg::ACR_ST_ADDR,
            acr_pkg::ACR_ST_REG,
            acr_pkg::ACR_ST_WRITE:
            begin
               if (!ack_ph_reg)
               begin
                  if (scl_rise && bit_cnt_reg != acr_pkg::BYTE_BITS)
                  begin
                     shift_next = {shift_reg[6:0], sda_s2};
                     bit_cnt_next = bit_cnt_reg + 4'h1;
                  end
                  if (scl_fall && bit_cnt_reg == acr_pkg::BYTE_BITS)
                  begin
                     bit_cnt_next = '0;
                     ack_ph_next = 1'b1;
                     drive_next = 1'b1;
                     if (state_reg == acr_pkg::ACR_ST_ADDR &&
                         shift_reg[7:1] != DEV_ADDR)
                     begin
                        state_next = acr_pkg::ACR_ST_IDLE;
                        drive_next = 1'b0;
                     end
                     if (state_reg == acr_pkg::ACR_ST_REG)
                     begin
                        ptr_next = shift_reg;
                     end
                     if (state_reg == acr_pkg::ACR_ST_WRITE)
                     begin
                        wr_stb_next = 1'b1;
                        wr_data_next = shift_reg;
                     end
                  end
               end
               else if (scl_fall)
               begin
                  ack_ph_next = 1'b0;
                  drive_next = 1'b0;
                  if (state_reg == acr_pkg::ACR_ST_WRITE)
                  begin
                     ptr_next = ptr_inc;
                  end
                  else if (state_reg == acr_pkg::ACR_ST_REG)
                  begin
                     state_next = acr_pkg::ACR_ST_WRITE;
                  end
                  else if (shift_reg[0])
                  begin
                     state_next = acr_pkg::ACR_ST_READ;
                     shift_next = rd_cur;
                     drive_next = ~rd_cur[7];
                     rd_stb_next = 1'b1;
                     rd_addr_next = ptr_reg;
                  end
                  else
                  begin
                     state_next = acr_pkg::ACR_ST_REG;
                  end
               end
            end
            acr_pkg::ACR_ST_READ:
            begin
               if (!ack_ph_reg && scl_fall)
               begin
                  if (bit_cnt_reg == acr_pkg::LAST_BIT)
                  begin
                     bit_cnt_next = '0;
                     ack_ph_next = 1'b1;
                     drive_next = 1'b0;
                  end
                  else
                  begin
                     bit_cnt_next = bit_cnt_reg + 4'h1;
                     shift_next = {shift_reg[6:0], 1'b0};
                     drive_next = ~shift_reg[6];
                  end
               end
               else if (ack_ph_reg && scl_rise)
               begin
                  nack_next = sda_s2;
               end
               else if (ack_ph_reg && scl_fall)
               begin
                  ack_ph_next = 1'b0;
                  if (nack_reg)
                  begin
                     state_next = acr_pkg::ACR_ST_IDLE;
                  end
                  else
                  begin
                     ptr_next = ptr_inc;
                     shift_next = rd_inc;
                     drive_next = ~rd_inc[7];
                     rd_stb_next = 1'b1;
                     rd_addr_next = ptr_inc;
                  end
               end
            end
            default:
            begin
               drive_next = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         state_reg <= acr_pkg::ACR_ST_IDLE;
         bit_cnt_reg <= '0;
         shift_reg <= acr_pkg::BYTE_ZERO;
         ptr_reg <= acr_pkg::BYTE_ZERO;
         wr_data_reg <= acr_pkg::BYTE_ZERO;
         rd_addr_reg <= acr_pkg::BYTE_ZERO;
         ack_ph_reg <= 1'b0;
         drive_reg <= 1'b0;
         nack_reg <= 1'b0;
         wr_stb_reg <= 1'b0;
         rd_stb_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         bit_cnt_reg <= bit_cnt_next;
         shift_reg <= shift_next;
         ptr_reg <= ptr_next;
         wr_data_reg <= wr_data_next;
         rd_addr_reg <= rd_addr_next;
         ack_ph_reg <= ack_ph_next;
         drive_reg <= drive_next;
         nack_reg <= nack_next;
         wr_stb_reg <= wr_stb_next;
         rd_stb_reg <= rd_stb_next;
      end
   end

   assign running = main_reg[acr_pkg::RUN_BIT]; // R1
   // stopped-only fields; the host must clear run first
   assign wr_ok = wr_stb_reg && !running; // R3 R8 R12 R20
   assign axis_hits = {2'h0, motion_event_i} & axis_reg; // R17

   // register file, interrupt sources, reboot
   always_comb
   begin
      main_next = main_reg;
      aux_next = aux_reg;
      pin_next = pin_reg;
      axis_next = axis_reg;
      src_func_next = src_func_reg;
      src_axis_next = src_axis_reg;
      reboot_cnt_next = reboot_cnt_reg;
      event_next = 1'b0;
      release_next = 1'b0;
      if (wr_stb_reg && ptr_reg == acr_pkg::ADDR_MAIN_CONTROL)
      begin
         if (running)
         begin
            main_next = (main_reg & ~acr_pkg::RUN_WMASK) |
                        (wr_data_reg & acr_pkg::RUN_WMASK); // R20
         end
         else
         begin
            main_next = wr_data_reg & acr_pkg::MAIN_WMASK; // R21
         end
      end
      if (wr_ok && ptr_reg == acr_pkg::ADDR_AUX_CONTROL)
      begin
         aux_next = wr_data_reg & acr_pkg::AUX_WMASK; // R21
      end
      if (wr_ok && ptr_reg == acr_pkg::ADDR_IRQ_PIN_CONFIG)
      begin
         pin_next = wr_data_reg & acr_pkg::PIN_WMASK; // R21
      end
      if (wr_ok && ptr_reg == acr_pkg::ADDR_MOTION_AXIS_EN)
      begin
         axis_next = wr_data_reg & acr_pkg::AXIS_WMASK; // R17 R21
      end
      if (rd_stb_reg && rd_addr_reg == acr_pkg::ADDR_SELFTEST_RESP)
      begin
         aux_next[acr_pkg::SELFTEST_BIT] = 1'b0; // R10
      end
      if (rd_stb_reg && rd_addr_reg == acr_pkg::ADDR_IRQ_RELEASE)
      begin
         src_func_next = acr_pkg::BYTE_ZERO; // R18
         src_axis_next = acr_pkg::BYTE_ZERO; // R18
         release_next = 1'b1; // R18
      end
      // set after clear: a coincident event survives
      if (running && main_reg[acr_pkg::NEW_SAMPLE_EN_BIT] && new_sample_i)
      begin
         src_func_next[acr_pkg::SRC_NEW_SAMPLE_BIT] = 1'b1; // R4
         event_next = 1'b1;
      end
      if (running && main_reg[acr_pkg::MOTION_EN_BIT] && |axis_hits)
      begin
         src_func_next[acr_pkg::SRC_MOTION_BIT] = 1'b1; // R7
         src_axis_next = src_axis_next | axis_hits; // R17
         event_next = 1'b1;
      end
      // reboot reloads defaults; bit stays set while counting
      reboot_cnt_next = '0;
      if (aux_reg[acr_pkg::REBOOT_BIT])
      begin
         reboot_cnt_next = reboot_cnt_reg + 16'h0001; // R9
         if (reboot_cnt_reg == 16'(REBOOT_CYCLES - 1))
         begin
            main_next = acr_pkg::MAIN_CONTROL_RST; // R9
            aux_next = acr_pkg::AUX_CONTROL_RST;
            pin_next = acr_pkg::IRQ_PIN_CONFIG_RST;
            axis_next = acr_pkg::MOTION_AXIS_EN_RST;
            reboot_cnt_next = '0;
         end
      end
      // 14-bit needs code 11 and full power
      if (!main_next[acr_pkg::PERF_BIT])
      begin
         width_next = acr_pkg::RES_8BIT; // R2
      end
      else if (main_next[acr_pkg::RANGE_HI_BIT:acr_pkg::RANGE_LO_BIT] ==
               acr_pkg::RANGE_8G_EXT)
      begin
         width_next = acr_pkg::RES_14BIT; // R6
      end
      else
      begin
         width_next = acr_pkg::RES_12BIT;
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         main_reg <= acr_pkg::MAIN_CONTROL_RST;
         aux_reg <= acr_pkg::AUX_CONTROL_RST;
         pin_reg <= acr_pkg::IRQ_PIN_CONFIG_RST; // R14
         axis_reg <= acr_pkg::MOTION_AXIS_EN_RST; // R17
         src_func_reg <= acr_pkg::BYTE_ZERO;
         src_axis_reg <= acr_pkg::BYTE_ZERO;
         reboot_cnt_reg <= '0;
         width_reg <= acr_pkg::RES_8BIT;
         event_reg <= 1'b0;
         release_reg <= 1'b0;
      end
      else
      begin
         main_reg <= main_next;
         aux_reg <= aux_next;
         pin_reg <= pin_next;
         axis_reg <= axis_next;
         src_func_reg <= src_func_next;
         src_axis_reg <= src_axis_next;
         reboot_cnt_reg <= reboot_cnt_next;
         width_reg <= width_next;
         event_reg <= event_next;
         release_reg <= release_next;
      end
   end

   acr_pin_if pin_bus ();
   assign pin_bus.pin_enable = pin_reg[acr_pkg::PIN_OUT_EN_BIT];
   assign pin_bus.pin_polarity = pin_reg[acr_pkg::PIN_POL_BIT];
   assign pin_bus.pin_pulse_mode = pin_reg[acr_pkg::PIN_PULSE_BIT];
   assign pin_bus.pending = |src_func_reg;
   assign pin_bus.event_stb = event_reg;
   assign pin_bus.release_stb = release_reg;

   acr_irq_pin u_irq_pin (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .pin(pin_bus),
      .irq_o(irq_o)
   );

   assign sda_o = 1'b0;
   assign sda_oe_n_o = ~drive_reg;
   assign run_o = main_reg[acr_pkg::RUN_BIT]; // R1
   assign performance_o = main_reg[acr_pkg::PERF_BIT]; // R2
   assign bandwidth_half_rate_o = main_reg[acr_pkg::PERF_BIT]; // R2
   assign range_o =
      main_reg[acr_pkg::RANGE_HI_BIT:acr_pkg::RANGE_LO_BIT]; // R5
   assign result_width_o = width_reg; // R6
   assign motion_detect_enable_o = main_reg[acr_pkg::MOTION_EN_BIT]; // R7
   assign motion_rate_o =
      aux_reg[acr_pkg::RATE_HI_BIT:acr_pkg::RATE_LO_BIT]; // R11
   assign actuation_polarity_o = pin_reg[acr_pkg::ACT_POL_BIT]; // R16
   assign reboot_busy_o = aux_reg[acr_pkg::REBOOT_BIT]; // R9
endmodule : acr_ctrl_regs

//--- design/acr_irq_pin.sv
// physical interrupt pin driver: latch or single pulse, polarity, enable
`timescale 1ns/100ps
module acr_irq_pin (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   acr_pin_if.drv pin,
   output logic irq_o
);
   logic [acr_pkg::PULSE_CNT_W-1:0] cnt_reg;
   logic [acr_pkg::PULSE_CNT_W-1:0] cnt_next;
   logic fired_reg;
   logic fired_next;
   logic irq_reg;
   logic irq_next;
   logic active;

   always_comb
   begin
      cnt_next = cnt_reg;
      fired_next = fired_reg;
      if (cnt_reg != '0)
      begin
         cnt_next = cnt_reg - 1'b1;
      end
      if (pin.release_stb)
      begin
         fired_next = 1'b0;
      end
      // one pulse per release; event in release cycle wins
      if (pin.event_stb && pin.pin_pulse_mode &&
          (!fired_reg || pin.release_stb)) // R15
      begin
         cnt_next = acr_pkg::PULSE_CYCLES;
         fired_next = 1'b1;
      end
      active = pin.pin_pulse_mode ? (cnt_reg != '0) : pin.pending; // R15
      // disabled pin rests at its inactive level
      if (pin.pin_enable && active) // R13
      begin
         irq_next = pin.pin_polarity; // R14
      end
      else
      begin
         irq_next = ~pin.pin_polarity; // R14
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         cnt_reg <= '0;
         fired_reg <= 1'b0;
         irq_reg <= 1'b0;
      end
      else
      begin
         cnt_reg <= cnt_next;
         fired_reg <= fired_next;
         irq_reg <= irq_next;
      end
   end

   assign irq_o = irq_reg;
endmodule : acr_irq_pin

//--- design/acr_pin_if.sv
// interrupt pin configuration and events between register file and driver
`timescale 1ns/100ps
interface acr_pin_if;
   logic pin_enable;
   logic pin_polarity;
   logic pin_pulse_mode;
   logic pending;
   logic event_stb;
   logic release_stb;
   modport ctrl (
      output pin_enable,
      output pin_polarity,
      output pin_pulse_mode,
      output pending,
      output event_stb,
      output release_stb
   );
   modport drv (
      input pin_enable,
      input pin_polarity,
      input pin_pulse_mode,
      input pending,
      input event_stb,
      input release_stb
   );
endinterface : acr_pin_if

//--- design/acr_pkg.sv
// constants and types shared by the accelerometer control register block
package acr_pkg;
   // register addresses
   localparam logic [7:0] ADDR_SELFTEST_RESP = 8'h0C;
   localparam logic [7:0] ADDR_SRC_FUNC = 8'h16;
   localparam logic [7:0] ADDR_SRC_AXIS = 8'h17;
   localparam logic [7:0] ADDR_STATUS = 8'h18;
   localparam logic [7:0] ADDR_IRQ_RELEASE = 8'h1A;
   localparam logic [7:0] ADDR_MAIN_CONTROL = 8'h1B;
   localparam logic [7:0] ADDR_AUX_CONTROL = 8'h1D;
   localparam logic [7:0] ADDR_IRQ_PIN_CONFIG = 8'h1E;
   localparam logic [7:0] ADDR_MOTION_AXIS_EN = 8'h1F;
   // reset values
   localparam logic [7:0] MAIN_CONTROL_RST = 8'h00;
   localparam logic [7:0] AUX_CONTROL_RST = 8'h00;
   localparam logic [7:0] IRQ_PIN_CONFIG_RST = 8'h10;
   localparam logic [7:0] MOTION_AXIS_EN_RST = 8'h3F;
   // writable bits
   localparam logic [7:0] MAIN_WMASK = 8'hFA;
   localparam logic [7:0] RUN_WMASK = 8'h80;
   localparam logic [7:0] AUX_WMASK = 8'h97;
   localparam logic [7:0] PIN_WMASK = 8'h3A;
   localparam logic [7:0] AXIS_WMASK = 8'h3F;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   // field positions
   localparam int RUN_BIT = 7;
   localparam int PERF_BIT = 6;
   localparam int NEW_SAMPLE_EN_BIT = 5;
   localparam int RANGE_HI_BIT = 4;
   localparam int RANGE_LO_BIT = 3;
   localparam int MOTION_EN_BIT = 1;
   localparam int REBOOT_BIT = 7;
   localparam int SELFTEST_BIT = 4;
   localparam int RATE_HI_BIT = 2;
   localparam int RATE_LO_BIT = 0;
   localparam int PIN_OUT_EN_BIT = 5;
   localparam int PIN_POL_BIT = 4;
   localparam int PIN_PULSE_BIT = 3;
   localparam int ACT_POL_BIT = 1;
   localparam int AXIS_HI_BIT = 5;
   localparam int SRC_NEW_SAMPLE_BIT = 4;
   localparam int SRC_MOTION_BIT = 1;
   localparam int STATUS_IRQ_BIT = 4;
   // self-test response values
   localparam logic [7:0] RESP_IDLE = 8'h55;
   localparam logic [7:0] RESP_TEST = 8'hAA;
   // range and result width codes
   localparam logic [1:0] RANGE_8G_EXT = 2'h3;
   localparam logic [1:0] RES_8BIT = 2'h0;
   localparam logic [1:0] RES_12BIT = 2'h1;
   localparam logic [1:0] RES_14BIT = 2'h2;
   // timing
   localparam longint CLK_FREQ_KHZ = 50000;
   localparam longint PULSE_TIME_NS = 40000;
   localparam int PULSE_CNT_W = 12;
   localparam logic [PULSE_CNT_W-1:0] PULSE_CYCLES =
      PULSE_CNT_W'(PULSE_TIME_NS * CLK_FREQ_KHZ / 1000000);
   // serial link
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam logic [3:0] LAST_BIT = 4'h7;
   typedef enum logic [2:0] {
      ACR_ST_IDLE = 3'b000,
      ACR_ST_ADDR = 3'b001,
      ACR_ST_REG = 3'b010,
      ACR_ST_WRITE = 3'b011,
      ACR_ST_READ = 3'b100
   } acr_link_state_t;
endpackage : acr_pkg

//--- tb/acr_asserts.sv
// port assertions for the accelerometer control registers
`timescale 1ns/100ps
module acr_asserts #(
   parameter int REBOOT_CYCLES = 64
) (
   input logic clk_sys_i,
   input logic rst_i,
   input logic irq_o,
   input logic run_o,
   input logic performance_o,
   input logic bandwidth_half_rate_o,
   input logic [1:0] range_o,
   input logic [1:0] result_width_o,
   input logic motion_detect_enable_o,
   input logic [2:0] motion_rate_o,
   input logic actuation_polarity_o,
   input logic reboot_busy_o
);
   logic [15:0] busy_reg, busy_next;
   // how long the reboot flag has stood
   always_comb
   begin
      busy_next = reboot_busy_o ? busy_reg + 16'h0001 : 16'h0000;
   end
   always_ff @(posedge clk_sys_i)
   begin
      busy_reg <= rst_i ? 16'h0000 : busy_next;
   end
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);
   chk_reset_state: assert property (disable iff (1'b0)
      rst_i |=> !run_o && !reboot_busy_o && !irq_o && range_o == 2'h0)
      else $error("reset state wrong");
   chk_perf_bw: assert property (
      bandwidth_half_rate_o == performance_o)
      else $error("bandwidth mismatch");
   chk_width_code: assert property (
      result_width_o == (!performance_o ? acr_pkg::RES_8BIT :
      range_o == acr_pkg::RANGE_8G_EXT ? acr_pkg::RES_14BIT :
      acr_pkg::RES_12BIT))
      else $error("width code wrong");
   chk_main_locked: assert property (
      $changed(range_o) || $changed(performance_o) ||
      $changed(motion_detect_enable_o) |-> !$past(run_o))
      else $error("main field changed running");
   chk_aux_locked: assert property (
      $changed(motion_rate_o) || $changed(actuation_polarity_o) |->
      !$past(run_o))
      else $error("aux field changed running");
   chk_reboot_start: assert property (
      $rose(reboot_busy_o) |-> !$past(run_o))
      else $error("reboot while running");
   chk_reboot_len: assert property (
      $fell(reboot_busy_o) |->
      busy_reg >= REBOOT_CYCLES && busy_reg <= REBOOT_CYCLES + 1)
      else $error("reboot length wrong");
   chk_reboot_clear: assert property (
      $fell(reboot_busy_o) |-> ##[0:2]
      (!run_o && range_o == 2'h0 && motion_rate_o == 3'h0))
      else $error("reboot left registers");
endmodule : acr_asserts
bind acr_ctrl_regs acr_asserts #(.REBOOT_CYCLES(REBOOT_CYCLES))
   acr_asserts_inst (.clk_sys_i, .rst_i, .irq_o, .run_o, .performance_o,
   .bandwidth_half_rate_o, .range_o, .result_width_o,
   .motion_detect_enable_o, .motion_rate_o, .actuation_polarity_o,
   .reboot_busy_o);

//--- tb/acr_host_model.sv
// behavioural two-wire host that writes and reads device registers
`timescale 1ns/100ps
module acr_host_model #(
   parameter logic [6:0] DEV_ADDR = 7'h2A
) (
   input logic clk_sys_i,
   input logic sda_i,
   output logic scl_o,
   output logic sda_o
);
   int nacks = 0;
   initial scl_o = 1'b1;
   initial sda_o = 1'b1;
   task automatic q(input int n);
      repeat (n) @(posedge clk_sys_i);
   endtask : q
   // data moves after clock fall: no false start
   task automatic bit_io(input logic b, output logic r);
      q(1);
      sda_o <= b;
      q(3);
      scl_o <= 1'b1;
      q(3);
      r = sda_i;
      q(1);
      scl_o <= 1'b0;
   endtask : bit_io
   // s=1 start, s=0 stop; clock left low after start, high after stop
   task automatic frame(input logic s);
      q(1);
      sda_o <= s;
      q(3);
      scl_o <= 1'b1;
      q(4);
      sda_o <= !s;
      q(4);
      if (s)
         scl_o <= 1'b0;
   endtask : frame
   task automatic xfer(input logic [7:0] d, input logic m, input logic c,
      output logic [7:0] r);
      logic a;
      for (int i = 7; i >= 0; i--)
         bit_io(d[i], r[i]);
      bit_io(m, a);
      if (c && a !== 1'b0)
         nacks++;
   endtask : xfer
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] r;
      frame(1'b1);
      xfer({DEV_ADDR, 1'b0}, 1'b1, 1'b1, r);
      xfer(a, 1'b1, 1'b1, r);
      xfer(d, 1'b1, 1'b1, r);
      frame(1'b0);
   endtask : write_reg
   task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
      logic [7:0] r;
      frame(1'b1);
      xfer({DEV_ADDR, 1'b0}, 1'b1, 1'b1, r);
      xfer(a, 1'b1, 1'b1, r);
      frame(1'b1);
      xfer({DEV_ADDR, 1'b1}, 1'b1, 1'b1, r);
      xfer(8'hFF, 1'b1, 1'b0, d);
      frame(1'b0);
   endtask : read_reg
endmodule : acr_host_model

//--- tb/test_accel_control_registers.sv
// bench driving the control registers through a modelled host
`timescale 1ns/100ps
module test_accel_control_registers;
   localparam int REBOOT = 400;
   localparam logic [15:0] RST_TBL [6] = '{16'h1B00, 16'h1D00,
      16'h1E10, 16'h1F3F, 16'h0C55, 16'h3000};
   logic clk_sys_i = 1'b0;
   logic rst_i = 1'b1;
   logic new_sample_i = 1'b0;
   logic [5:0] motion_event_i = 6'h00;
   logic scl, sda_h, sda_d, sda_oe_n, irq, perf, rd_stb = 1'b0;
   logic [1:0] range;
   logic [2:0] rate;
   logic [7:0] rd_byte, rnd, tmp;
   logic [7:0] exp_q[$];
   int errors = 0, n_checks = 0, cyc = 0, seed = 37032;
   wire sda = sda_h & (sda_oe_n | sda_d);
   initial forever #10 clk_sys_i = ~clk_sys_i;
   acr_ctrl_regs #(.REBOOT_CYCLES(REBOOT)) acr_ctrl_regs_inst (
      .clk_sys_i(clk_sys_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda),
      .sda_o(sda_d), .sda_oe_n_o(sda_oe_n), .new_sample_i(new_sample_i),
      .motion_event_i(motion_event_i), .irq_o(irq), .run_o(),
      .performance_o(perf), .bandwidth_half_rate_o(), .range_o(range),
      .result_width_o(), .motion_detect_enable_o(), .motion_rate_o(rate),
      .actuation_polarity_o(), .reboot_busy_o());
   acr_host_model acr_host_model_inst (.clk_sys_i(clk_sys_i),
      .sda_i(sda), .scl_o(scl), .sda_o(sda_h));
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic print_verdict;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : print_verdict
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      acr_host_model_inst.write_reg(a, d);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      acr_host_model_inst.read_reg(a, rd_byte);
      rd_stb <= 1'b1;
      @(posedge clk_sys_i);
      rd_stb <= 1'b0;
   endtask : rd
   task automatic ev(input logic s, input logic [5:0] m);
      new_sample_i <= s;
      motion_event_i <= m;
      @(posedge clk_sys_i);
      new_sample_i <= 1'b0;
      motion_event_i <= 6'h00;
      repeat (8) @(posedge clk_sys_i);
   endtask : ev
   always @(posedge clk_sys_i)
      if (rd_stb)
         check(rd_byte, exp_q.pop_front());
   always @(posedge clk_sys_i)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         errors++;
         print_verdict();
      end
   end
   initial
   begin
      rnd = 8'($random(seed));
      repeat (8) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      repeat (4) @(posedge clk_sys_i);
      foreach (RST_TBL[i])
         rd(RST_TBL[i][15:8], RST_TBL[i][7:0]);
      $display("reset values done");
      wr(8'h1B, rnd & 8'h7F);
      rd(8'h1B, rnd & 8'h7A);
      check(8'(range), 8'(rnd[4:3]));
      check(8'(perf), 8'(rnd[6]));
      wr(8'h1D, 8'h10 | (rnd & 8'h07));
      check(8'(rate), 8'(rnd[2:0]));
      rd(8'h0C, 8'hAA);
      rd(8'h0C, 8'h55);
      rd(8'h1D, rnd & 8'h07);
      $display("config and self-test done");
      wr(8'h1B, 8'h80);
      wr(8'h1E, 8'h3A);
      rd(8'h1E, 8'h10);
      wr(8'h1B, 8'h00);
      wr(8'h1E, 8'h30);
      wr(8'h1B, 8'h82);
      ev(1'b1, 6'h00);
      check(8'(irq), 8'h00);
      ev(1'b0, 6'h24);
      check(8'(irq), 8'h01);
      rd(8'h17, 8'h24);
      rd(8'h16, 8'h02);
      acr_host_model_inst.read_reg(8'h1A, tmp);
      check(8'(irq), 8'h00);
      rd(8'h16, 8'h00);
      $display("latched interrupt done");
      wr(8'h1B, 8'h00);
      wr(8'h1E, 8'h38);
      wr(8'h1B, 8'hA0);
      ev(1'b1, 6'h00);
      check(8'(irq), 8'h01);
      repeat (1900) @(posedge clk_sys_i);
      check(8'(irq), 8'h01);
      repeat (200) @(posedge clk_sys_i);
      check(8'(irq), 8'h00);
      $display("pulsed interrupt done");
      wr(8'h1B, 8'h00);
      wr(8'h1D, 8'h80);
      rd(8'h1D, 8'h80);
      repeat (REBOOT) @(posedge clk_sys_i);
      rd(8'h1E, 8'h10);
      check(8'(acr_host_model_inst.nacks), 8'h00);
      $display("reboot done");
      print_verdict();
   end
endmodule : test_accel_control_registers
